// File: hw/crpm_pkg.sv
`default_nettype none
package crpm_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] CRPM_ADDR_EXTERNAL_INTERRUPT_FLAGS   = 8'h91;
	localparam logic [7:0] CRPM_ADDR_PMCTL  = 8'hC4;
	localparam logic [7:0] CRPM_ADDR_STATUS = 8'hC5;

	localparam int CRPM_CD_HI_BIT   = 7;
	localparam int CRPM_CD_LO_BIT   = 6;
	localparam int CRPM_ARE_BIT     = 5;
	localparam int CRPM_XOFF_BIT    = 3;
	localparam int CRPM_SRC_BIT     = 3;
	localparam int CRPM_RING_BIT    = 2;
	localparam int CRPM_PF_BIT      = 7;
	localparam int CRPM_HI_BIT      = 6;
	localparam int CRPM_LO_BIT      = 5;
	localparam int CRPM_XRDY_BIT    = 4;
	localparam int CRPM_ACT_LSB     = 0;

	localparam logic [1:0] CRPM_CD_RSVD = 2'h0;
	localparam logic [1:0] CRPM_CD_4    = 2'h1;
	localparam logic [1:0] CRPM_CD_64   = 2'h2;
	localparam logic [1:0] CRPM_CD_1024 = 2'h3;

	localparam int CRPM_DIV_4    = 4;
	localparam int CRPM_DIV_64   = 64;
	localparam int CRPM_DIV_1024 = 1024;
	localparam int CRPM_XTAL_WARMUP = 65536;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crpm_sfr_t;

	typedef struct packed {
		logic [1:0] irq_req;
		logic [1:0] irq_en;
		logic [1:0] irq_high;
		logic       pf_active;
		logic       hi_active;
		logic       lo_active;
	} crpm_irq_t;

	typedef struct packed {
		logic [1:0] rx_en;
		logic [1:0] start_edge;
		logic [1:0] tx_write;
		logic [1:0] rx_busy;
		logic [1:0] tx_busy;
	} crpm_serial_t;
endpackage
`default_nettype wire

// File: hw/crpm_cycle_rate.sv
// What this block does
// - default instruction cycle equals four source clocks.
// - reduced-speed mode keeps running at source/64 or source/1024.
// - divider code 00 reserved, 01 four (reset), 10 sixty-four, 11 1024.
// - a new divider takes effect after one instruction cycle.
// - the cycle strobe clocks every function, timers and baud included.
// - 64 or 1024 accepted only while current rate is four clocks.
// - only software writes enter reduced-speed mode.
// - restore enable bit allows hardware return to four clocks.
// - enabled, valid external interrupt triggers restore.
// - interrupt restores only if it could actually be taken.
// - start-bit edge on enabled receiver triggers restore.
// - write to either transmit buffer triggers restore.
// - start-bit detection raises no interrupt itself.
// - three read-only bits show levels in service.
// - port 0 receive and transmit activity bits.
// - same activity bits for port 1.
// - ring source divided by 4, 64 or 1024 likewise.
// - divider and source selections are independent.
// - source bit 1 crystal, 0 ring, after one cycle; ring flag reads 1.
// - crystal-off bit accepts 1 only while ring selected.
// - 65,536 crystal clocks before ready flag; crystal refused until ready.
// - restore changes divider only, never the source.
`default_nettype none
module crpm_cycle_rate
	import crpm_pkg::*;
#(
	parameter int WARMUP_CLOCKS = CRPM_XTAL_WARMUP
) (
	input  wire logic         i_clock,     // selected oscillator
	input  wire logic         i_rst_b,     // system reset
	input  wire crpm_sfr_t    i_sfr,       // register write port
	input  wire crpm_irq_t    i_irq,       // interrupt state
	input  wire crpm_serial_t i_serial,    // serial port state
	output logic              o_cycle,     // one-clock instruction cycle strobe
	output logic [7:0]        o_external_interrupt_flags,      // readback of external flags bits
	output logic [7:0]        o_pmctl,     // readback of power control
	output logic [7:0]        o_status,    // readback of status
	output logic              o_use_ring,  // ring drives the core
	output logic              o_xtal_off,  // crystal amplifier disabled
	output logic              o_restored   // one-clock restore pulse
);
	// ************************************************************
	// state
	// ************************************************************
	logic [1:0]  cd, next_cd, cd_pend, next_cd_pend;
	logic        are, next_are;
	logic        xoff, next_xoff;
	logic        src_xtal, next_src_xtal, src_pend, next_src_pend;
	logic        xrdy, next_xrdy;
	logic [16:0] warm, next_warm;
	logic [9:0]  div, next_div;
	logic        cyc, next_cyc;
	logic        rst_pulse, next_rst_pulse;
	logic        wr_pm, wr_ex, restore, irq_ok;

	function automatic logic [9:0] div_limit(input logic [1:0] code);
		case (code)
			CRPM_CD_64:   div_limit = 10'(CRPM_DIV_64 - 1);
			CRPM_CD_1024: div_limit = 10'(CRPM_DIV_1024 - 1);
			default:      div_limit = 10'(CRPM_DIV_4 - 1);
		endcase
	endfunction

	assign wr_pm = i_sfr.wr && (i_sfr.addr == CRPM_ADDR_PMCTL);
	assign wr_ex = i_sfr.wr && (i_sfr.addr == CRPM_ADDR_EXTERNAL_INTERRUPT_FLAGS);

	// ************************************************************
	// restore qualification
	// ************************************************************
	always_comb begin
		irq_ok = 1'b0;
		for (int k = 0; k < 2; k++) begin
			// a source must outrank the level in service to be taken
			if (i_irq.irq_req[k] && i_irq.irq_en[k] && !i_irq.pf_active) begin
				if (i_irq.irq_high[k] ? !i_irq.hi_active
						: !(i_irq.hi_active || i_irq.lo_active)) begin
					irq_ok = 1'b1;
				end
			end
		end
		// start edges feed restore only; no interrupt is raised from them
		restore = are && (irq_ok || |(i_serial.start_edge & i_serial.rx_en)
			|| |i_serial.tx_write);
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_comb begin
		next_cd        = cd;
		next_cd_pend   = cd_pend;
		next_are       = are;
		next_xoff      = xoff;
		next_src_xtal  = src_xtal;
		next_src_pend  = src_pend;
		next_xrdy      = xrdy;
		next_warm      = warm;
		next_rst_pulse = 1'b0;
		if (wr_pm) begin
			next_are = i_sfr.wdata[CRPM_ARE_BIT];
			// only software reaches the slow codes, and only from four clocks
			if (i_sfr.wdata[CRPM_CD_HI_BIT:CRPM_CD_LO_BIT] == CRPM_CD_4) begin
				next_cd_pend = CRPM_CD_4;
			end else if (i_sfr.wdata[CRPM_CD_HI_BIT:CRPM_CD_LO_BIT] != CRPM_CD_RSVD
					&& cd == CRPM_CD_4 && cd_pend == CRPM_CD_4) begin
				next_cd_pend = i_sfr.wdata[CRPM_CD_HI_BIT:CRPM_CD_LO_BIT];
			end
			if (i_sfr.wdata[CRPM_XOFF_BIT]) begin
				if (!src_pend && !src_xtal) begin
					next_xoff = 1'b1;
					next_xrdy = 1'b0;
				end
			end else if (xoff) begin
				next_xoff = 1'b0;
				next_warm = '0;
			end
		end
		if (wr_ex) begin
			if (!i_sfr.wdata[CRPM_SRC_BIT]) begin
				next_src_pend = 1'b0;
			end else if (xrdy && !xoff) begin
				next_src_pend = 1'b1;
			end
		end
		if (!xoff && !xrdy) begin
			next_warm = warm + 17'h00001;
			if (warm == 17'(WARMUP_CLOCKS - 1)) begin
				next_xrdy = 1'b1;
			end
		end
		if (restore && (next_cd_pend != CRPM_CD_4 || cd != CRPM_CD_4)) begin
			next_cd_pend   = CRPM_CD_4;
			next_cd        = CRPM_CD_4;
			next_rst_pulse = 1'b1;
		end else if (cyc) begin
			next_cd       = cd_pend;
			next_src_xtal = src_pend;
		end
	end

	// ************************************************************
	// cycle divider
	// ************************************************************
	always_comb begin
		next_cyc = 1'b0;
		next_div = div + 10'h001;
		if (div >= div_limit(next_cd)) begin
			next_div = '0;
			next_cyc = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cd        <= CRPM_CD_4;
			cd_pend   <= CRPM_CD_4;
			are       <= 1'b0;
			xoff      <= 1'b0;
			src_xtal  <= 1'b1;
			src_pend  <= 1'b1;
			xrdy      <= 1'b1;
			warm      <= '0;
			div       <= '0;
			cyc       <= 1'b0;
			rst_pulse <= 1'b0;
		end else begin
			cd        <= next_cd;
			cd_pend   <= next_cd_pend;
			are       <= next_are;
			xoff      <= next_xoff;
			src_xtal  <= next_src_xtal;
			src_pend  <= next_src_pend;
			xrdy      <= next_xrdy;
			warm      <= next_warm;
			div       <= next_div;
			cyc       <= next_cyc;
			rst_pulse <= next_rst_pulse;
		end
	end

	// ************************************************************
	// readback; start-bit edges feed only restore, never an interrupt
	// ************************************************************
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_external_interrupt_flags     <= 8'h08;
			o_pmctl    <= 8'h40;
			o_status   <= 8'h10;
			o_use_ring <= 1'b0;
			o_xtal_off <= 1'b0;
			o_cycle    <= 1'b0;
			o_restored <= 1'b0;
		end else begin
			o_external_interrupt_flags     <= '0;
			o_external_interrupt_flags[CRPM_SRC_BIT]  <= next_src_pend;
			o_external_interrupt_flags[CRPM_RING_BIT] <= !next_src_xtal;
			o_pmctl    <= '0;
			o_pmctl[CRPM_CD_HI_BIT:CRPM_CD_LO_BIT] <= next_cd_pend;
			o_pmctl[CRPM_ARE_BIT]  <= next_are;
			o_pmctl[CRPM_XOFF_BIT] <= next_xoff;
			o_status   <= '0;
			o_status[CRPM_PF_BIT]   <= i_irq.pf_active;
			o_status[CRPM_HI_BIT]   <= i_irq.hi_active;
			o_status[CRPM_LO_BIT]   <= i_irq.lo_active;
			o_status[CRPM_XRDY_BIT] <= next_xrdy;
			for (int p = 0; p < 2; p++) begin
				o_status[CRPM_ACT_LSB + 2*p]     <= i_serial.rx_busy[p];
				o_status[CRPM_ACT_LSB + 2*p + 1] <= i_serial.tx_busy[p];
			end
			o_use_ring <= !next_src_xtal;
			o_xtal_off <= next_xoff;
			o_cycle    <= next_cyc;
			o_restored <= next_rst_pulse;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sequence s_slow_write;
		wr_pm && i_sfr.wdata[CRPM_CD_HI_BIT] && cd != CRPM_CD_4;
	endsequence

	a_no_direct_slow: assert property (s_slow_write |=> cd_pend == $past(cd_pend)
		|| cd_pend == CRPM_CD_4) else $error("slow code accepted off four clocks");
	a_reserved_ignored: assert property (wr_pm
		&& i_sfr.wdata[CRPM_CD_HI_BIT:CRPM_CD_LO_BIT] == CRPM_CD_RSVD
		&& !restore |=> cd_pend == $past(cd_pend)) else $error("reserved code applied");
	a_restore_four: assert property (restore |=> cd == CRPM_CD_4
		&& cd_pend == CRPM_CD_4) else $error("restore missed");
	a_restore_src_kept: assert property (restore && !cyc |=> src_xtal == $past(src_xtal))
		else $error("restore touched source");
	a_no_restore_off: assert property (!are |=> !rst_pulse)
		else $error("restore while disabled");
	a_four_rate: assert property (cd == CRPM_CD_4 && cd_pend == CRPM_CD_4 && o_cycle
		&& !restore ##1 !restore [*3] |=> o_cycle) else $error("four clock rate wrong");
	a_xoff_guard: assert property (wr_pm && i_sfr.wdata[CRPM_XOFF_BIT] && src_xtal
		&& !xoff |=> !xoff) else $error("crystal off while selected");
	a_xtal_refused: assert property (wr_ex && i_sfr.wdata[CRPM_SRC_BIT] && !xrdy
		&& !src_pend |=> !src_pend) else $error("crystal taken before ready");
	a_ring_flag: assert property (o_use_ring == o_external_interrupt_flags[CRPM_RING_BIT])
		else $error("ring flag mismatch");
endmodule // crpm_cycle_rate
`default_nettype wire

// File: testbench/crpm_core_model.sv
`default_nettype none
module crpm_core_model
	import crpm_pkg::*;
(
	input  wire logic       i_clock, // core clock
	output var crpm_irq_t    o_irq,   // interrupt state to the block
	output var crpm_serial_t o_ser    // serial state to the block
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_irq = '0;
		o_ser = '0;
	end
	// levels change only on an edge, so the block never sees a mid-cycle glitch
	task automatic levels(input crpm_irq_t irq, input crpm_serial_t ser);
		@(posedge i_clock);
		o_irq <= irq;
		o_ser <= ser;
	endtask
	// one-clock event pulses: start edge, buffer write, interrupt request
	task automatic pulse(input logic [1:0] se, input logic [1:0] tw, input logic [1:0] rq);
		@(posedge i_clock);
		o_ser.start_edge <= se;
		o_ser.tx_write   <= tw;
		o_irq.irq_req    <= rq;
		@(posedge i_clock);
		o_ser.start_edge <= 2'h0;
		o_ser.tx_write   <= 2'h0;
		o_irq.irq_req    <= 2'h0;
	endtask
endmodule // crpm_core_model
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top;
	import crpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic         i_clock, i_rst_b, o_cycle, o_use_ring, o_restored;
	logic [7:0]   o_external_interrupt_flags, o_pmctl, o_status;
	crpm_sfr_t    i_sfr;
	crpm_irq_t    irq, ti;
	crpm_serial_t ser, ts;
	int           n_mismatch, comparisons, per, i;
	logic [15:0]  c;
	logic [6:0]   act;
	// {rq, en, high, pf/hi/lo, rx_en0, start0, tx0, -, restore expected}
	logic [15:0]  cases [8] = '{16'h1440, 16'h1401, 16'h2A21, 16'h1000,
		16'h0008, 16'h0019, 16'h0005, 16'h2A80};
	crpm_cycle_rate #(.WARMUP_CLOCKS(16)) u_crpm_cycle_rate (.i_clock(i_clock),
		.i_rst_b(i_rst_b), .i_sfr(i_sfr), .i_irq(irq), .i_serial(ser), .o_cycle(o_cycle),
		.o_external_interrupt_flags(o_external_interrupt_flags), .o_pmctl(o_pmctl), .o_status(o_status), .o_use_ring(o_use_ring),
		.o_xtal_off(), .o_restored(o_restored));
	crpm_core_model u_crpm_core_model (.i_clock(i_clock), .o_irq(irq), .o_ser(ser));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic test_done;
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			n_mismatch++;
			$display("unexpected at %0t: period %0d, wanted %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_sfr <= '{1'b1, a, d};
		@(posedge i_clock);
		i_sfr.wr <= 1'b0;
		@(posedge i_clock);
		#1;
	endtask
	// first interval skipped: it may straddle a rate change
	task automatic period(output int p);
		int k, n;
		k = 0;
		n = 0;
		p = 0;
		while (k < 3) begin
			@(posedge i_clock);
			#1;
			n++;
			if (n > 5000) begin
				n_mismatch++;
				test_done();
			end
			if (k == 2) p++;
			if (o_cycle === 1'b1) k++;
		end
	endtask
	task automatic saw_restore(input logic exp);
		logic s;
		s = 1'b0;
		// the pulse stands in the clock right after the event edge
		#1;
		if (o_restored === 1'b1) s = 1'b1;
		repeat (6) begin
			@(posedge i_clock);
			#1;
			if (o_restored === 1'b1) s = 1'b1;
		end
		chk_reg({7'h0, s}, {7'h0, exp});
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		n_mismatch = 0;
		comparisons = 0;
		i_sfr = '0;
		i_rst_b = 1'b0;
		void'($urandom(32'h3C7A));
		repeat (10) @(posedge i_clock);
		i_rst_b <= 1'b1;
		#1;
		chk_reg(o_external_interrupt_flags, 8'h08);
		chk_reg(o_pmctl, 8'h40);
		chk_reg(o_status, 8'h10);
		period(per);
		chk_cnt(per, CRPM_DIV_4);
		wr(CRPM_ADDR_PMCTL, 8'h00);
		chk_reg(o_pmctl, 8'h40);
		wr(CRPM_ADDR_PMCTL, 8'h48);
		chk_reg(o_pmctl, 8'h40);
		wr(CRPM_ADDR_PMCTL, 8'h80);
		period(per);
		chk_cnt(per, CRPM_DIV_64);
		wr(CRPM_ADDR_PMCTL, 8'hC0);
		chk_reg(o_pmctl, 8'h80);
		u_crpm_core_model.pulse(2'h0, 2'h2, 2'h0);
		saw_restore(1'b0);
		wr(CRPM_ADDR_PMCTL, 8'h60);
		period(per);
		chk_cnt(per, CRPM_DIV_4);
		for (i = 0; i < 8; i++) begin
			c = cases[i];
			wr(CRPM_ADDR_PMCTL, {1'b1, i[0], 6'h20});
			period(per);
			chk_cnt(per, i[0] ? CRPM_DIV_1024 : CRPM_DIV_64);
			ti = '{2'h0, c[11:10], c[9:8], c[7], c[6], c[5]};
			ts = '{{1'b0, c[4]}, 2'h0, 2'h0, 2'h0, 2'h0};
			u_crpm_core_model.levels(ti, ts);
			u_crpm_core_model.pulse({1'b0, c[3]}, {1'b0, c[2]}, c[13:12]);
			saw_restore(c[0]);
			chk_reg(o_pmctl, c[0] ? 8'h60 : {1'b1, i[0], 6'h20});
			wr(CRPM_ADDR_PMCTL, 8'h60);
			u_crpm_core_model.levels('0, '0);
			period(per);
			chk_cnt(per, CRPM_DIV_4);
		end
		repeat (8) begin
			act = 7'($urandom);
			ti = '{2'h0, 2'h0, 2'h0, act[6], act[5], act[4]};
			ts = '{2'h0, 2'h0, 2'h0, {act[2], act[0]}, {act[3], act[1]}};
			u_crpm_core_model.levels(ti, ts);
			repeat (3) @(posedge i_clock);
			#1;
			chk_reg(o_status, {act[6:4], 1'b1, act[3:0]});
		end
		u_crpm_core_model.levels('0, '0);
		wr(CRPM_ADDR_EXTERNAL_INTERRUPT_FLAGS, 8'h00);
		period(per);
		chk_cnt(per, CRPM_DIV_4);
		chk_reg(o_external_interrupt_flags, 8'h04);
		wr(CRPM_ADDR_PMCTL, 8'h68);
		chk_reg(o_pmctl, 8'h68);
		wr(CRPM_ADDR_EXTERNAL_INTERRUPT_FLAGS, 8'h08);
		chk_reg(o_external_interrupt_flags, 8'h04);
		wr(CRPM_ADDR_PMCTL, 8'hA8);
		period(per);
		chk_cnt(per, CRPM_DIV_64);
		u_crpm_core_model.pulse(2'h0, 2'h1, 2'h0);
		saw_restore(1'b1);
		chk_reg({7'h0, o_use_ring}, 8'h01);
		wr(CRPM_ADDR_PMCTL, 8'h60);
		chk_reg({7'h0, o_status[4]}, 8'h00);
		// warm-up shortened to 16 clocks; allow margin for the readback
		for (i = 0; i < 40 && o_status[4] !== 1'b1; i++) @(posedge i_clock);
		#1;
		chk_reg({7'h0, o_status[4]}, 8'h01);
		wr(CRPM_ADDR_EXTERNAL_INTERRUPT_FLAGS, 8'h08);
		period(per);
		chk_reg(o_external_interrupt_flags, 8'h08);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
